/* rtl/spd_link_if.sv */
// Three-wire serial programming link between programmer and divider core.
// Assumes the load strobe pin has a pull-up: undriven, it reads high.
interface spd_link_if;
	logic serClk;
	logic serData;
	logic loadOut;
	logic loadOe;
	logic loadStrobe;

	// Pull-up resolution of the load strobe wire
	assign loadStrobe = loadOe ? loadOut : 1'b1;

	modport host (
		output serClk,
		output serData,
		output loadOut,
		output loadOe
	);

	modport dev (
		input serClk,
		input serData,
		input loadStrobe
	);
endinterface

/* rtl/spd_pkg.sv */
// Shared constants of the serial-programmed divider core and its programmer.
// Assumes a 50 MHz system clock on both ends of the three-wire link.
package spd_pkg;

	// System clock rate
	localparam int CLK_MHZ = 50;

	// Serial link timing, figures in ns, counts in system cycles (rounded up)
	localparam int SER_HALF_NS = 1000;
	localparam int LE_WIDTH_NS = 800;
	localparam logic [7:0] SER_HALF_CYC = 8'((SER_HALF_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] LE_CYC = 8'((LE_WIDTH_NS * CLK_MHZ + 999) / 1000);

	// Word lengths on the serial link
	localparam logic [4:0] REF_BITS = 5'h10;
	localparam logic [4:0] MAIN_BITS = 5'h13;

	// Shift register field positions (bit 0 is the last bit shifted in)
	localparam int SR_CTRL = 0;
	localparam int SR_MOD = 1;
	localparam int SR_REF_LO = 2;
	localparam int SR_REF_HI = 15;
	localparam int SR_SWL_LO = 1;
	localparam int SR_SWL_HI = 7;
	localparam int SR_MAIN_LO = 8;
	localparam int SR_MAIN_HI = 18;

	// Prescaler lower moduli
	localparam logic [7:0] MOD_LOW_A = 8'h40;
	localparam logic [7:0] MOD_LOW_B = 8'h80;

	// Latch values after reset
	localparam logic [13:0] REF_RATIO_RST = 14'h0006;
	localparam logic MOD_BIT_RST = 1'b1;
	localparam logic [6:0] SWALLOW_RST = 7'h00;
	localparam logic [10:0] MAIN_RATIO_RST = 11'h010;

	// Synchroniser lanes in the device
	localparam int SY_SCLK = 0;
	localparam int SY_SDAT = 1;
	localparam int SY_LOAD = 2;
	localparam int SY_XTAL = 3;
	localparam int SY_VCO = 4;
	localparam int SY_POL = 5;
	localparam int SY_W = 6;

	// Programmer register offsets (byte addresses)
	localparam logic [7:0] ADDR_REF = 8'h00;
	localparam logic [7:0] ADDR_MAIN = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;

	// Programmer sequencer states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_LOW    = 3'b001,
		ST_HIGH   = 3'b010,
		ST_STROBE = 3'b011,
		ST_GAP    = 3'b100
	} spd_state_t;

endpackage

/* rtl/spd_prog_host.sv */
// Programmer for the divider core: AHB-Lite register slave that turns
// register writes into serial words with a load strobe.
// Assumes a single AHB-Lite master; transfers are whole words.
module spd_prog_host
	import spd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	spd_link_if.host         link
);

	spd_state_t  state_q;
	spd_state_t  state_d;
	logic [7:0]  tmr_q;
	logic [7:0]  tmr_d;
	logic [4:0]  bitsLeft_q;
	logic [4:0]  bitsLeft_d;
	logic [18:0] word_q;
	logic [18:0] word_d;
	logic        serClk_q;
	logic        serClk_d;
	logic        serData_q;
	logic        serData_d;
	logic        load_q;
	logic        load_d;
	logic        wrPend_q;
	logic        wrPend_d;
	logic [7:0]  wrAddr_q;
	logic [7:0]  wrAddr_d;
	logic [14:0] refShadow_q;
	logic [14:0] refShadow_d;
	logic [17:0] mainShadow_q;
	logic [17:0] mainShadow_d;
	logic [31:0] hrdata_q;
	logic [31:0] hrdata_d;
	logic        addrPhase;
	logic        busy;

	// Bus decode, register file and serial sequencer
	always_comb begin
		addrPhase = hsel && hready && htrans[1];
		busy = (state_q != ST_IDLE);
		wrPend_d = addrPhase && hwrite;
		wrAddr_d = addrPhase ? haddr[7:0] : wrAddr_q;
		// Read data prepared in the address phase; unmapped reads zero
		hrdata_d = hrdata_q;
		if (addrPhase && !hwrite) begin
			case (haddr[7:0])
				ADDR_REF: hrdata_d = {17'h00000, refShadow_q};
				ADDR_MAIN: hrdata_d = {14'h0000, mainShadow_q};
				ADDR_STAT: hrdata_d = {31'h00000000, busy};
				default: hrdata_d = 32'h00000000;
			endcase
		end

		state_d = state_q;
		tmr_d = (tmr_q != 8'h00) ? tmr_q - 8'h01 : tmr_q;
		bitsLeft_d = bitsLeft_q;
		word_d = word_q;
		serClk_d = serClk_q;
		serData_d = serData_q;
		load_d = load_q;
		refShadow_d = refShadow_q;
		mainShadow_d = mainShadow_q;

		case (state_q)
			ST_IDLE: begin
				// Writes while busy are dropped, not queued
				// reference ratio below 6 dropped
				if (wrPend_q && wrAddr_q == ADDR_REF && hwdata[14:1] >= 14'h0006) begin
					refShadow_d = hwdata[14:0];
					word_d = {hwdata[14:0], 1'b1, 3'h0};
					bitsLeft_d = REF_BITS;
					state_d = ST_LOW;
				end else if (wrPend_q && wrAddr_q == ADDR_MAIN && hwdata[17:7] >= 11'h010
					&& {4'h0, hwdata[6:0]} < hwdata[17:7]) begin
					mainShadow_d = hwdata[17:0];
					word_d = {hwdata[17:0], 1'b0};
					bitsLeft_d = MAIN_BITS;
					state_d = ST_LOW;
				end
				if (state_d == ST_LOW) begin
					serData_d = word_d[18];
					tmr_d = SER_HALF_CYC;
				end
			end
			ST_LOW: begin
				if (tmr_q == 8'h00) begin
					serClk_d = 1'b1;
					tmr_d = SER_HALF_CYC;
					state_d = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (tmr_q == 8'h00) begin
					serClk_d = 1'b0;
					tmr_d = SER_HALF_CYC;
					bitsLeft_d = bitsLeft_q - 5'h01;
					if (bitsLeft_q == 5'h01) begin
						state_d = ST_STROBE;
					end else begin
						word_d = {word_q[17:0], 1'b0};
						serData_d = word_q[17];
						state_d = ST_LOW;
					end
				end
			end
			ST_STROBE: begin
				// Strobe raised a half period after the last fall
				if (tmr_q == 8'h00 && !load_q) begin
					load_d = 1'b1;
					tmr_d = LE_CYC;
				end else if (tmr_q == 8'h00) begin
					load_d = 1'b0;
					tmr_d = SER_HALF_CYC;
					state_d = ST_GAP;
				end
			end
			ST_GAP: begin
				if (tmr_q == 8'h00) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Register stage; synchronous reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			tmr_q <= 8'h00;
			bitsLeft_q <= 5'h00;
			word_q <= 19'h00000;
			serClk_q <= 1'b0;
			serData_q <= 1'b0;
			load_q <= 1'b0;
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
			refShadow_q <= 15'h0000;
			mainShadow_q <= 18'h00000;
			hrdata_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			bitsLeft_q <= bitsLeft_d;
			word_q <= word_d;
			serClk_q <= serClk_d;
			serData_q <= serData_d;
			load_q <= load_d;
			wrPend_q <= wrPend_d;
			wrAddr_q <= wrAddr_d;
			refShadow_q <= refShadow_d;
			mainShadow_q <= mainShadow_d;
			hrdata_q <= hrdata_d;
		end
	end

	// Zero-wait slave, always OKAY; strobe driven at all times
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign link.serClk = serClk_q;
	assign link.serData = serData_q;
	assign link.loadOut = load_q;
	assign link.loadOe = 1'b1;

endmodule // spd_prog_host

/* rtl/spd_synth_core.sv */
// Digital core of the serial-programmed synthesizer: shift register,
// latches, reference / swallow / main dividers and phase comparator.
// Assumes link pins, crystal and prescaler input arrive asynchronously.
// Operation
// - Each serial clock rise shifts one bit in
// - Last bit high loads reference latch
// - Last bit low with strobe loads main latch
// - Strobe high or open transfers stored data
// - Reference word: 14 ratio, modulus, high control
// - Reference word goes MSB first
// - Reference ratio binary, 6 to 16383
// - Modulus bit high 64/65, low 128/129
// - Main word: 18 ratio bits, low control
// - Main word goes MSB first
// - Bits 1-7 give swallow count
// - Bits 8-18 give main counter ratio
// - Main ratio kept within 16 to 2047
// - Swallow count below main ratio
// - Total division is modulus times N plus A
// - Lock flag rests high, low on error
// - Polarity pin low inverts comparator sense
// - Monitor shows ref or main by polarity
// - Open-drain pump only pulls low
// - Lead, lag, aligned output table per polarity
// - Modulus used is upper of pair while swallow count runs, lower after
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
module spd_synth_core
	import spd_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	spd_link_if.dev   link,
	input  wire logic crystalInput,
	input  wire logic vcoIn,
	input  wire logic phasePolarityPin,
	output logic      phaseErrorFlag,
	output logic      pumpOut,
	output logic      pumpOe,
	output logic      refPumpOut,
	output logic      odPumpOut,
	output logic      odPumpOe,
	output logic      monitorOut
);

	// Synchroniser and edge history
	logic [SY_W-1:0] syncA_q;
	logic [SY_W-1:0] syncB_q;
	logic [2:0]      prev_q;
	logic [2:0]      prev_d;

	// Shift register and latches
	logic [18:0] shift_q;
	logic [18:0] shift_d;
	logic [13:0] refRatio_q;
	logic [13:0] refRatio_d;
	logic        prescalerModulusBit_q;
	logic        prescalerModulusBit_d;
	logic [6:0]  swallowRatio_q;
	logic [6:0]  swallowRatio_d;
	logic [10:0] mainRatio_q;
	logic [10:0] mainRatio_d;

	// Counters
	logic [13:0] refCnt_q;
	logic [13:0] refCnt_d;
	logic [7:0]  prescCnt_q;
	logic [7:0]  prescCnt_d;
	logic [6:0]  swCnt_q;
	logic [6:0]  swCnt_d;
	logic [10:0] mainCnt_q;
	logic [10:0] mainCnt_d;

	// Comparator state and registered outputs
	logic up_q;
	logic up_d;
	logic dn_q;
	logic dn_d;
	logic refDividerOut_q;
	logic refDividerOut_d;
	logic mainDividerOut_q;
	logic mainDividerOut_d;
	logic phaseErrorFlag_q;
	logic phaseErrorFlag_d;
	logic pumpOut_q;
	logic pumpOut_d;
	logic pumpOe_q;
	logic pumpOe_d;
	logic refPumpOut_q;
	logic refPumpOut_d;
	logic odPumpOe_q;
	logic odPumpOe_d;
	logic monitorOut_q;
	logic monitorOut_d;

	// Combinational helpers
	logic       serRise;
	logic       xtalRise;
	logic       vcoRise;
	logic       refPulse;
	logic       mainPulse;
	logic       prescTick;
	logic [7:0] modulus;
	logic       lead;
	logic       lag;

	// Two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge clk) begin
		syncA_q <= {phasePolarityPin, vcoIn, crystalInput,
			link.loadStrobe, link.serData, link.serClk};
		syncB_q <= syncA_q;
	end

	// Next-state logic of the whole core
	always_comb begin
		prev_d = {syncB_q[SY_VCO], syncB_q[SY_XTAL], syncB_q[SY_SCLK]};
		serRise = syncB_q[SY_SCLK] & ~prev_q[0];
		xtalRise = syncB_q[SY_XTAL] & ~prev_q[1];
		vcoRise = syncB_q[SY_VCO] & ~prev_q[2];

		shift_d = serRise ? {shift_q[17:0], syncB_q[SY_SDAT]} : shift_q;

		refRatio_d = refRatio_q;
		prescalerModulusBit_d = prescalerModulusBit_q;
		swallowRatio_d = swallowRatio_q;
		mainRatio_d = mainRatio_q;
		if (syncB_q[SY_LOAD]) begin
			if (shift_q[SR_CTRL]) begin
				refRatio_d = shift_q[SR_REF_HI:SR_REF_LO];
				prescalerModulusBit_d = shift_q[SR_MOD];
			end else begin
				swallowRatio_d = shift_q[SR_SWL_HI:SR_SWL_LO];
				mainRatio_d = shift_q[SR_MAIN_HI:SR_MAIN_LO];
			end
		end

		refPulse = 1'b0;
		refCnt_d = refCnt_q;
		if (xtalRise) begin
			if (refCnt_q <= 14'h0001) begin
				refCnt_d = refRatio_q;
				refPulse = 1'b1;
			end else begin
				refCnt_d = refCnt_q - 14'h0001;
			end
		end

		modulus = prescalerModulusBit_q ? MOD_LOW_A : MOD_LOW_B;
		if (swCnt_q != 7'h00) begin
			modulus = modulus + 8'h01;
		end
		prescTick = 1'b0;
		prescCnt_d = prescCnt_q;
		if (vcoRise) begin
			if (prescCnt_q >= modulus - 8'h01) begin
				prescCnt_d = 8'h00;
				prescTick = 1'b1;
			end else begin
				prescCnt_d = prescCnt_q + 8'h01;
			end
		end

		// N prescaler periods, A of them long
		mainPulse = 1'b0;
		swCnt_d = swCnt_q;
		mainCnt_d = mainCnt_q;
		if (prescTick) begin
			if (mainCnt_q <= 11'h001) begin
				mainCnt_d = mainRatio_q;
				swCnt_d = swallowRatio_q;
				mainPulse = 1'b1;
			end else begin
				mainCnt_d = mainCnt_q - 11'h001;
				if (swCnt_q != 7'h00) begin
					swCnt_d = swCnt_q - 7'h01;
				end
			end
		end

		// Phase-frequency detector; both set means aligned, so clear
		up_d = up_q | refPulse;
		dn_d = dn_q | mainPulse;
		if (up_d && dn_d) begin
			up_d = 1'b0;
			dn_d = 1'b0;
		end

		lead = syncB_q[SY_POL] ? up_d : dn_d;
		lag = syncB_q[SY_POL] ? dn_d : up_d;
		pumpOut_d = lead;
		pumpOe_d = lead | lag;
		refPumpOut_d = lag;
		odPumpOe_d = lead;
		phaseErrorFlag_d = ~(up_d | dn_d);

		refDividerOut_d = refPulse;
		mainDividerOut_d = mainPulse;
		monitorOut_d = syncB_q[SY_POL] ? refDividerOut_q : mainDividerOut_q;
	end

	// State registers, synchronous reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_q <= 3'h0;
			shift_q <= 19'h00000;
			refRatio_q <= REF_RATIO_RST;
			prescalerModulusBit_q <= MOD_BIT_RST;
			swallowRatio_q <= SWALLOW_RST;
			mainRatio_q <= MAIN_RATIO_RST;
			refCnt_q <= REF_RATIO_RST;
			prescCnt_q <= 8'h00;
			swCnt_q <= SWALLOW_RST;
			mainCnt_q <= MAIN_RATIO_RST;
			up_q <= 1'b0;
			dn_q <= 1'b0;
			refDividerOut_q <= 1'b0;
			mainDividerOut_q <= 1'b0;
			phaseErrorFlag_q <= 1'b1;
			pumpOut_q <= 1'b0;
			pumpOe_q <= 1'b0;
			refPumpOut_q <= 1'b0;
			odPumpOe_q <= 1'b0;
			monitorOut_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			shift_q <= shift_d;
			refRatio_q <= refRatio_d;
			prescalerModulusBit_q <= prescalerModulusBit_d;
			swallowRatio_q <= swallowRatio_d;
			mainRatio_q <= mainRatio_d;
			refCnt_q <= refCnt_d;
			prescCnt_q <= prescCnt_d;
			swCnt_q <= swCnt_d;
			mainCnt_q <= mainCnt_d;
			up_q <= up_d;
			dn_q <= dn_d;
			refDividerOut_q <= refDividerOut_d;
			mainDividerOut_q <= mainDividerOut_d;
			phaseErrorFlag_q <= phaseErrorFlag_d;
			pumpOut_q <= pumpOut_d;
			pumpOe_q <= pumpOe_d;
			refPumpOut_q <= refPumpOut_d;
			odPumpOe_q <= odPumpOe_d;
			monitorOut_q <= monitorOut_d;
		end
	end

	// Output drive straight from flops; open drain level is always low
	assign phaseErrorFlag = phaseErrorFlag_q;
	assign pumpOut = pumpOut_q;
	assign pumpOe = pumpOe_q;
	assign refPumpOut = refPumpOut_q;
	assign odPumpOut = 1'b0;
	assign odPumpOe = odPumpOe_q;
	assign monitorOut = monitorOut_q;

endmodule // spd_synth_core

/* sim/spd_link_assertions.sv */
// Checker for the three-wire programming link between programmer and core.
// Assumes it watches the interface wires directly in the clk domain.
module spd_link_assertions
	import spd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic serClk,
	input wire logic serData,
	input wire logic loadOut,
	input wire logic loadOe,
	input wire logic loadStrobe
);
	logic [18:0] shReg_q;
	logic [4:0]  bitCnt_q;
	logic [7:0]  hiCnt_q;
	logic        clkPrev_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Mirror of the shift register; the count clears while the strobe is up
	always_ff @(posedge clk) begin
		clkPrev_q <= serClk;
		hiCnt_q <= serClk ? hiCnt_q + 8'h01 : 8'h00;
		if (!rst_n) begin
			bitCnt_q <= 5'h00;
		end else if (serClk && !clkPrev_q) begin
			shReg_q <= {shReg_q[17:0], serData};
			bitCnt_q <= bitCnt_q + 5'h01;
		end else if (loadOut) begin
			bitCnt_q <= 5'h00;
		end
	end

	sequence s_load;
		$rose(loadOut);
	endsequence

	property p_oe;
		loadOe && (loadStrobe == loadOut);
	endproperty
	a_oe: assert property (p_oe) else $error("load strobe not driven");

	property p_hold;
		serClk |-> $stable(serData);
	endproperty
	a_hold: assert property (p_hold) else $error("data moved while clock high");

	property p_high;
		$fell(serClk) |-> hiCnt_q >= SER_HALF_CYC;
	endproperty
	a_high: assert property (p_high) else $error("serial clock high too short");

	property p_quiet;
		loadOut |-> !serClk;
	endproperty
	a_quiet: assert property (p_quiet) else $error("clock during strobe");

	property p_ctrl;
		s_load |-> shReg_q[0] == (bitCnt_q == REF_BITS);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control bit wrong");

	property p_len;
		s_load |-> (bitCnt_q == REF_BITS) || (bitCnt_q == MAIN_BITS);
	endproperty
	a_len: assert property (p_len) else $error("word length wrong");

	property p_ref;
		s_load ##0 shReg_q[0] |-> shReg_q[15:2] >= 14'h0006;
	endproperty
	a_ref: assert property (p_ref) else $error("reference ratio too low");

	property p_main;
		s_load ##0 !shReg_q[0] |-> shReg_q[18:8] >= 11'h010 && shReg_q[7:1] < shReg_q[18:8];
	endproperty
	a_main: assert property (p_main) else $error("main ratios illegal");
endmodule // spd_link_assertions

/* sim/tb.sv */
// Bench: AHB-Lite master, crystal and prescaler sources, link word capture.
// Assumes both ends joined by spd_link_if in one 50 MHz clk domain.
module tb
	import spd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        crystalInput = 1'b0;
	logic        vcoIn = 1'b0;
	logic        phasePolarityPin = 1'b1;
	logic        phaseErrorFlag, pumpOut, pumpOe, refPumpOut;
	logic        odPumpOut, odPumpOe, monitorOut;
	logic [31:0] capQ = 32'h0;
	int          capN = 0;
	int          fails = 0;
	int          checks_done = 0;
	int          cyc = 0;

	spd_link_if linkIf ();
	spd_prog_host spd_prog_host_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(linkIf.host));
	spd_synth_core spd_synth_core_inst (.clk(clk), .rst_n(rst_n), .link(linkIf.dev),
		.crystalInput(crystalInput), .vcoIn(vcoIn), .phasePolarityPin(phasePolarityPin),
		.phaseErrorFlag(phaseErrorFlag), .pumpOut(pumpOut), .pumpOe(pumpOe),
		.refPumpOut(refPumpOut), .odPumpOut(odPumpOut), .odPumpOe(odPumpOe),
		.monitorOut(monitorOut));
	spd_link_assertions spd_link_assertions_inst (.clk(clk), .rst_n(rst_n),
		.serClk(linkIf.serClk), .serData(linkIf.serData), .loadOut(linkIf.loadOut),
		.loadOe(linkIf.loadOe), .loadStrobe(linkIf.loadStrobe));

	// Sources toggle on the falling edge: crystal 8 clk, prescaler 4 clk
	always #10 clk = ~clk;
	always #80 crystalInput = ~crystalInput;
	always #40 vcoIn = ~vcoIn;

	// Capture of the wire word as the core sees it
	always @(posedge linkIf.serClk) begin
		capQ <= {capQ[30:0], linkIf.serData};
		capN <= capN + 1;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One single word transfer; read data taken at the data phase edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
		chk("bus response", 32'h0, {31'h0, hresp});
	endtask

	// Write a word, wait for the sequencer, judge the wire and the readback
	task automatic prog(input logic [7:0] a, input logic [31:0] d, input int n,
		input logic [31:0] expWord);
		logic [31:0] rd;
		int t;
		capN = 0;
		ahb(1'b1, a, d, rd);
		repeat (4) @(posedge clk);
		rd = 32'h1;
		for (t = 0; t < 3000 && rd[0] !== 1'b0; t++) ahb(1'b0, ADDR_STAT, 32'h0, rd);
		chk("status idle after word", 32'h0, rd);
		chk("link bit count", n, capN);
		chk("link word", expWord, capQ & ((32'h1 << n) - 32'h1));
		ahb(1'b0, a, 32'h0, rd);
		chk("register readback", d, rd);
	endtask

	task automatic gap(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (monitorOut !== 1'b1);
	endtask

	// First two gaps discarded: they span the polarity or ratio change
	task automatic period(input logic pol, input int exp);
		int n;
		phasePolarityPin <= pol;
		gap(n);
		gap(n);
		gap(n);
		chk("monitor period", exp, n);
	endtask

	task automatic test_regs();
		logic [31:0] rd;
		ahb(1'b0, ADDR_STAT, 32'h0, rd);
		chk("status idle", 32'h0, rd);
		ahb(1'b0, 8'h0c, 32'h0, rd);
		chk("unmapped read", 32'h0, rd);
		ahb(1'b1, ADDR_REF, 32'h0000000a, rd);
		ahb(1'b0, ADDR_STAT, 32'h0, rd);
		chk("status after illegal ref", 32'h0, rd);
		ahb(1'b0, ADDR_REF, 32'h0, rd);
		chk("ref after illegal ref", 32'h0, rd);
		ahb(1'b1, ADDR_MAIN, 32'h00000810, rd);
		ahb(1'b0, ADDR_STAT, 32'h0, rd);
		chk("status after illegal main", 32'h0, rd);
		ahb(1'b0, ADDR_MAIN, 32'h0, rd);
		chk("main after illegal main", 32'h0, rd);
		$display("test regs done");
	endtask

	task automatic test_ref();
		period(1'b1, 48);
		prog(ADDR_REF, 32'h13, 16, 32'h27);
		period(1'b1, 72);
		$display("test ref done");
	endtask

	task automatic test_main();
		prog(ADDR_MAIN, 32'h80f, 19, 32'h101e);
		period(1'b0, 4156);
		prog(ADDR_REF, 32'h12, 16, 32'h25);
		period(1'b0, 8252);
		$display("test main done");
	endtask

	// Reference runs far faster, so it always leads in phase
	task automatic phase(input logic pol);
		int good;
		int bad;
		good = 0;
		bad = 0;
		phasePolarityPin <= pol;
		repeat (20) @(posedge clk);
		repeat (2000) begin
			@(posedge clk);
			if (odPumpOut !== 1'b0 || (pumpOe === 1'b1 &&
				{pumpOut, refPumpOut, odPumpOe} !== {pol, !pol, pol})) bad++;
			if (pumpOe === 1'b1 && phaseErrorFlag === 1'b0) good++;
		end
		chk("pump sense errors", 32'h0, bad);
		chk("error flag low seen", 32'h1, good > 0);
		$display("test phase done");
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Ceiling well above the expected run of some 44000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 70000) begin
			fails++;
			$display("ERROR timeout expected done seen running");
			results();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		test_regs();
		test_ref();
		test_main();
		phase(1'b1);
		phase(1'b0);
		results();
	end
endmodule // tb
